// *** core/clk_ctrl_pkg.sv ***
package clk_ctrl_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_PROC_CLK   = 8'h00;
  localparam logic [7:0] ADDR_OSC_MODE   = 8'h04;
  localparam logic [7:0] ADDR_PERIPH_SEL = 8'h08;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int DIV_LSB        = 0;
  localparam int SRC_SEL_BIT    = 4;
  localparam int SRC_STAT_BIT   = 5;
  localparam int HS_STOP_BIT    = 0;
  localparam int LS_STOP_BIT    = 1;
  localparam int HS_STATE_BIT   = 7;
  localparam int PSEL_WATCH     = 0;
  localparam int PSEL_CLKOUT    = 1;
  localparam int PSEL_TMH1_LS   = 2;
  localparam int PSEL_TMH0_T50  = 3;
  localparam int PSEL_UART0_T50 = 4;
  localparam int PSEL_UART6_T50 = 5;
  localparam int PSEL_W         = 6;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [2:0] DIV_RST      = 3'h0;
  localparam logic [2:0] DIV_MAX      = 3'h4;
  localparam logic       SRC_MAIN     = 1'b0;
  localparam logic       SRC_SUB      = 1'b1;
  localparam int         DIV_BASE_CNT = 16;
  localparam int         SUB_EXIT_CNT = 2;
  localparam int         DLY_W        = 16;
endpackage : clk_ctrl_pkg

// *** core/cpu_clock_switch_control.sv ***
`timescale 1ns/100ps
// Function
// RULE_01 - Bit 5 of processor clock register reads which source drives CPU.
// RULE_02 - Writing one to high-speed stop bit halts the internal oscillator.
// RULE_03 - Software stops high-speed oscillator only when CPU runs elsewhere.
// RULE_04 - Software stops peripherals on that oscillator before stopping it.
// RULE_05 - Bits 0-2 pick main division; bit 4 picks main or subsystem.
// RULE_06 - New CPU setting takes effect only after a switchover delay.
// RULE_07 - Division change waits 16, 8, 4, 2 or 1 old clocks.
// RULE_08 - Main to sub waits scaled ratio cycles; sub to main waits two.
// RULE_09 - Software never changes division while moving from main to sub.
// RULE_10 - Division change together with sub to main return is accepted.
// RULE_11 - Peripheral clocks routed from their allowed selectable sources.
// RULE_12 - Software starts no pin-clocked peripheral while high-speed clocks stop.
// RULE_13 - Low-speed stop bit acts only when the option allows stopping.
// RULE_14 - High-speed stop control sits at bit 0 of oscillator mode register.
// RULE_15 - Bit 7 of oscillator mode register reports high-speed oscillator state.
// RULE_16 - Status follows only once delay ends and new clock drives CPU.
// RULE_17 - Reset returns all controls, CPU on internal high-speed oscillator.
module cpu_clock_switch_control
  import clk_ctrl_pkg::*;
#(
  parameter int FXP_PER_FSUB = 8
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mainTick,
  input  wire logic        subTick,
  input  wire logic        prsTick,
  input  wire logic        lsTick,
  input  wire logic        timerATick,
  input  wire logic        hsOscStatePin,
  input  wire logic        lsStoppableOptPin,
  output logic             cpuTick,
  output logic [2:0]       cpuDiv,
  output logic             cpuSource,
  output logic             hsOscRun,
  output logic             lsOscRun,
  output logic             wdtTick,
  output logic             watchTick,
  output logic             clkOutTick,
  output logic             tmrH1Tick,
  output logic             tmrH0Tick,
  output logic             uart0Tick,
  output logic             uart6Tick
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0]        hsSync;
    logic [1:0]        optSync;
    logic [2:0]        reqDiv;
    logic              reqSrc;
    logic [2:0]        actDiv;
    logic              actSrc;
    logic              hsStop;
    logic              lsStop;
    logic [PSEL_W-1:0] psel;
    logic [3:0]        divCnt;
    logic              cpuTick;
    logic              hsRun;
    logic              lsRun;
    logic              wdt;
    logic              watch;
    logic              clkOut;
    logic              tmrH1;
    logic              tmrH0;
    logic              uart0;
    logic              uart6;
    logic              ready;
    logic              err;
    logic [31:0]       rdata;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  switch_if sw ();

  switch_delay switch_delay_i (
    .mclk (mclk),
    .srst (srst),
    .sw   (sw.timer)
  );

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_PROC_CLK) || (a == ADDR_OSC_MODE) || (a == ADDR_PERIPH_SEL);
  endfunction : mapped

  function automatic logic [15:0] delay_for(input logic [2:0] oldDiv, input logic oldSrc,
                                            input logic newSrc);
    logic [15:0] v;
    v = 16'h0001;
    if (oldSrc == SRC_SUB) begin
      v = 16'(SUB_EXIT_CNT);  // RULE_08
    end else if (newSrc == SRC_SUB) begin
      v = 16'((2 * FXP_PER_FSUB) >> oldDiv);  // RULE_08
    end else begin
      v = 16'(DIV_BASE_CNT >> oldDiv);  // RULE_07
    end
    if (v == 16'h0000) begin
      v = 16'h0001;
    end
    delay_for = v;
  endfunction : delay_for

  logic        acc;
  logic        wrPcc;
  logic        mainDivTick;
  logic [3:0]  divMask;
  logic [2:0]  wDiv;
  logic        wSrc;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d         = s_q;
    acc         = psel && penable && !s_q.ready;
    wrPcc       = 1'b0;
    wDiv        = pwdata[DIV_LSB+2:DIV_LSB];
    wSrc        = pwdata[SRC_SEL_BIT];
    sw.start    = 1'b0;
    sw.count    = 16'h0001;
    s_d.hsSync  = {s_q.hsSync[0], hsOscStatePin};
    s_d.optSync = {s_q.optSync[0], lsStoppableOptPin};
    s_d.ready   = acc;
    s_d.err     = acc && !mapped(paddr);

    if (acc && pwrite) begin
      unique case (paddr)
        ADDR_PROC_CLK: begin
          // Out-of-range division codes are not taken
          if (wDiv <= DIV_MAX) begin
            s_d.reqDiv = wDiv;  // RULE_05
            s_d.reqSrc = wSrc;  // RULE_05 RULE_10
            wrPcc      = 1'b1;
          end
        end
        ADDR_OSC_MODE: begin
          s_d.hsStop = pwdata[HS_STOP_BIT];  // RULE_02 RULE_14
          s_d.lsStop = pwdata[LS_STOP_BIT];
        end
        ADDR_PERIPH_SEL: s_d.psel = pwdata[PSEL_W-1:0];
        default: ;
      endcase
    end

    if (acc && !pwrite) begin
      s_d.rdata = 32'h0000_0000;
      unique case (paddr)
        ADDR_PROC_CLK: begin
          s_d.rdata[DIV_LSB+2:DIV_LSB] = s_q.reqDiv;
          s_d.rdata[SRC_SEL_BIT]       = s_q.reqSrc;
          s_d.rdata[SRC_STAT_BIT]      = s_q.actSrc;  // RULE_01
        end
        ADDR_OSC_MODE: begin
          s_d.rdata[HS_STOP_BIT]  = s_q.hsStop;
          s_d.rdata[LS_STOP_BIT]  = s_q.lsStop;
          s_d.rdata[HS_STATE_BIT] = s_q.hsSync[1];  // RULE_15
        end
        ADDR_PERIPH_SEL: s_d.rdata[PSEL_W-1:0] = s_q.psel;
        default: ;
      endcase
    end

    // Delay starts from the setting in force, so the old clock sets the pace
    if (wrPcc && (wDiv != s_q.actDiv || wSrc != s_q.actSrc)) begin
      sw.start = 1'b1;  // RULE_06
      sw.count = delay_for(s_q.actDiv, s_q.actSrc, wSrc);
    end
    if (sw.done) begin
      s_d.actDiv = s_q.reqDiv;  // RULE_16
      s_d.actSrc = s_q.reqSrc;  // RULE_16
    end

    // Old-setting CPU clock; divider free runs on the main tick
    divMask     = 4'((5'h01 << s_q.actDiv) - 5'h01);
    mainDivTick = mainTick && ((s_q.divCnt & divMask) == divMask);
    if (mainTick) begin
      s_d.divCnt = s_q.divCnt + 4'h1;
    end
    s_d.cpuTick = (s_q.actSrc == SRC_SUB) ? subTick : mainDivTick;
    sw.tick     = s_d.cpuTick;

    s_d.hsRun  = !s_q.hsStop;  // RULE_02
    s_d.lsRun  = !(s_q.lsStop && !s_q.optSync[1]);  // RULE_13
    s_d.wdt    = lsTick && s_d.lsRun;  // RULE_11
    s_d.watch  = s_q.psel[PSEL_WATCH] ? subTick : prsTick;  // RULE_11
    s_d.clkOut = s_q.psel[PSEL_CLKOUT] ? subTick : prsTick;  // RULE_11
    s_d.tmrH1  = s_q.psel[PSEL_TMH1_LS] ? (lsTick && s_d.lsRun) : prsTick;  // RULE_11
    s_d.tmrH0  = s_q.psel[PSEL_TMH0_T50] ? timerATick : prsTick;  // RULE_11
    s_d.uart0  = s_q.psel[PSEL_UART0_T50] ? timerATick : prsTick;  // RULE_11
    s_d.uart6  = s_q.psel[PSEL_UART6_T50] ? timerATick : prsTick;  // RULE_11
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q        <= '0;  // RULE_17
      s_q.reqDiv <= DIV_RST;
      s_q.actDiv <= DIV_RST;
      s_q.reqSrc <= SRC_MAIN;
      s_q.actSrc <= SRC_MAIN;
      s_q.hsRun  <= 1'b1;
      s_q.lsRun  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata     = s_q.rdata;
  assign pready     = s_q.ready;
  assign pslverr    = s_q.err;
  assign cpuTick    = s_q.cpuTick;
  assign cpuDiv     = s_q.actDiv;
  assign cpuSource  = s_q.actSrc;
  assign hsOscRun   = s_q.hsRun;
  assign lsOscRun   = s_q.lsRun;
  assign wdtTick    = s_q.wdt;
  assign watchTick  = s_q.watch;
  assign clkOutTick = s_q.clkOut;
  assign tmrH1Tick  = s_q.tmrH1;
  assign tmrH0Tick  = s_q.tmrH0;
  assign uart0Tick  = s_q.uart0;
  assign uart6Tick  = s_q.uart6;
endmodule : cpu_clock_switch_control

// *** core/switch_delay.sv ***
`timescale 1ns/100ps
module switch_delay
  import clk_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  switch_if.timer  sw
);
  typedef struct packed {
    logic             busy;
    logic [DLY_W-1:0] remain;
    logic             done;
  } dly_state_t;

  dly_state_t s_q;
  dly_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (sw.start) begin
      // Restart on a fresh request; the old target is abandoned
      s_d.busy   = 1'b1;
      s_d.remain = sw.count;
    end else if (s_q.busy && sw.tick) begin
      if (s_q.remain <= 16'h0001) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;  // RULE_06
      end else begin
        s_d.remain = s_q.remain - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sw.done = s_q.done;
endmodule : switch_delay

// *** core/switch_if.sv ***
`timescale 1ns/100ps
interface switch_if;
  logic        start;
  logic [15:0] count;
  logic        tick;
  logic        done;
  modport ctrl  (output start, output count, output tick, input done);
  modport timer (input start, input count, input tick, output done);
endinterface : switch_if

// *** testbench/clk_ctrl_chk.sv ***
`timescale 1ns/100ps
// ****************************************
// Port checks
// ****************************************
module clk_ctrl_chk
  import clk_ctrl_pkg::*;
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        lsTick,
  input wire logic        lsStoppableOptPin,
  input wire logic        cpuTick,
  input wire logic [2:0]  cpuDiv,
  input wire logic        cpuSource,
  input wire logic        hsOscRun,
  input wire logic        lsOscRun,
  input wire logic        wdtTick
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  unmapped_err_a: assert property (pready && paddr > ADDR_PERIPH_SEL |-> pslverr)
    else $error("unmapped access without error");
  reset_values_a: assert property (disable iff (1'b0) srst |=> cpuDiv == DIV_RST && !cpuSource && hsOscRun
    && lsOscRun && !pready) else $error("reset values wrong");
  hs_stop_a: assert property (psel && penable && !pready && pwrite && paddr == ADDR_OSC_MODE
    |-> ##2 hsOscRun == !$past(pwdata[HS_STOP_BIT], 2)) else $error("hsOscRun not following stop bit");
  ls_keep_a: assert property (lsStoppableOptPin [*4] |-> lsOscRun) else $error("ls osc stopped");
  div_range_a: assert property (cpuDiv <= DIV_MAX) else $error("division code out of range");
  switch_edge_a: assert property ($changed({cpuSource, cpuDiv}) |-> $past(cpuTick))
    else $error("setting changed off a cpu tick");
  status_read_a: assert property (pready && !pwrite && paddr == ADDR_PROC_CLK
    |-> prdata[SRC_STAT_BIT] == $past(cpuSource)) else $error("status bit differs from source");
  wdt_source_a: assert property (wdtTick |-> $past(lsTick)) else $error("wdt tick not from ls");
endmodule : clk_ctrl_chk

bind cpu_clock_switch_control clk_ctrl_chk clk_ctrl_chk_i (.*);

// *** testbench/tb_cpu_clock_switch_control.sv ***
`timescale 1ns/100ps
module tb_cpu_clock_switch_control
  import clk_ctrl_pkg::*;
;
  // ****************************************
  // Bench
  // ****************************************
  localparam int FXP = 8;
  logic        mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        lsStoppableOptPin = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, cpuTick, cpuSource, hsOscRun, lsOscRun, err;
  logic [2:0]  cpuDiv;
  logic        mainTick, subTick, prsTick, lsTick, timerATick, hsOscStatePin;
  logic [6:0]  pt;
  int          failures = 0, checks_done = 0, tickCnt = 0;
  always #2 mclk = ~mclk;
  // Old-setting ticks; the tick shown in the ready cycle predates the write
  always @(posedge mclk) tickCnt <= pready ? 0 : tickCnt + int'(cpuTick);
  tick_source tick_source_i (.mclk(mclk), .srst(srst), .hsOscRun(hsOscRun), .mainTick(mainTick),
    .subTick(subTick), .prsTick(prsTick), .lsTick(lsTick), .timerATick(timerATick),
    .hsOscStatePin(hsOscStatePin));
  cpu_clock_switch_control #(.FXP_PER_FSUB(FXP)) cpu_clock_switch_control_i (.mclk(mclk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mainTick(mainTick), .subTick(subTick), .prsTick(prsTick),
    .lsTick(lsTick), .timerATick(timerATick), .hsOscStatePin(hsOscStatePin),
    .lsStoppableOptPin(lsStoppableOptPin), .cpuTick(cpuTick), .cpuDiv(cpuDiv), .cpuSource(cpuSource),
    .hsOscRun(hsOscRun), .lsOscRun(lsOscRun), .wdtTick(pt[0]), .watchTick(pt[1]), .clkOutTick(pt[2]),
    .tmrH1Tick(pt[3]), .tmrH0Tick(pt[4]), .uart0Tick(pt[5]), .uart6Tick(pt[6]));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdat    = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), rdat, x);
  endtask : rd

  task automatic sw(input logic s, input logic [2:0] dv, input int n);
    int i;
    wr(ADDR_PROC_CLK, {27'h0, s, 1'b0, dv});
    for (i = 0; i < 400 && {cpuSource, cpuDiv} !== {s, dv}; i++) @(posedge mclk);
    chk("switch ticks", 32'(tickCnt), 32'(n));
    chk("active setting", {28'h0, cpuSource, cpuDiv}, {28'h0, s, dv});
  endtask : sw

  task automatic periph(input logic sel);
    logic [6:0] prev;
    for (int k = 0; k < 16; k++) begin
      prev = sel ? {{3{timerATick}}, lsTick, subTick, subTick, lsTick} : {{6{prsTick}}, lsTick};
      @(posedge mclk);
      chk("peripheral ticks", 32'(pt), 32'(prev));
    end
  endtask : periph

  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  initial begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    chk("reset outputs", {26'h0, hsOscRun, lsOscRun, cpuSource, cpuDiv}, 32'h30);
    rd(ADDR_PROC_CLK, 32'h0);
    rd(ADDR_OSC_MODE, 32'h80);
    for (int d = 0; d < 5; d++) sw(1'b0, 3'((d + 1) % 5), 16 >> d);
    wr(ADDR_PROC_CLK, 32'h5);
    rd(ADDR_PROC_CLK, 32'h0);
    sw(1'b0, 3'h2, 16);
    sw(1'b1, 3'h2, (2 * FXP) >> 2);
    rd(ADDR_PROC_CLK, 32'h32);
    // CPU is off the internal oscillator before it is stopped
    wr(ADDR_OSC_MODE, 32'h1);
    repeat (6) @(posedge mclk);
    chk("hs run", 32'(hsOscRun), 32'h0);
    rd(ADDR_OSC_MODE, 32'h1);
    lsStoppableOptPin <= 1'b1;
    wr(ADDR_OSC_MODE, 32'h2);
    repeat (6) @(posedge mclk);
    chk("ls run kept", 32'(lsOscRun), 32'h1);
    lsStoppableOptPin <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("ls run", 32'(lsOscRun), 32'h0);
    rd(ADDR_OSC_MODE, 32'h82);
    wr(ADDR_OSC_MODE, 32'h0);
    sw(1'b0, 3'h0, 2);
    rd(ADDR_PROC_CLK, 32'h0);
    chk("hs run before start", 32'(hsOscRun), 32'h1);
    wr(ADDR_PERIPH_SEL, 32'h3f);
    rd(ADDR_PERIPH_SEL, 32'h3f);
    periph(1'b1);
    wr(ADDR_PERIPH_SEL, 32'h0);
    periph(1'b0);
    repeat (40) @(posedge mclk);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped error", 32'(err), 32'h1);
    conclude();
  end

  initial begin
    #40000;
    failures++;
    conclude();
  end
endmodule : tb_cpu_clock_switch_control

// *** testbench/tick_source.sv ***
`timescale 1ns/100ps
// ****************************************
// Oscillators and source ticks
// ****************************************
module tick_source (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic hsOscRun,
  output logic      mainTick,
  output logic      subTick,
  output logic      prsTick,
  output logic      lsTick,
  output logic      timerATick,
  output logic      hsOscStatePin
);
  logic [3:0] cnt_q;
  always_ff @(posedge mclk) begin
    cnt_q         <= srst ? 4'h0 : cnt_q + 4'h1;
    hsOscStatePin <= hsOscRun;
  end
  // Main clock dies with the oscillator, so a bad stop hangs the CPU
  assign mainTick   = hsOscStatePin;
  assign subTick    = cnt_q[2:0] == 3'h7;
  assign prsTick    = cnt_q[0];
  assign lsTick     = cnt_q[1:0] == 2'h3;
  assign timerATick = cnt_q == 4'h9;
endmodule : tick_source
